// >>> core/ies_pkg.sv
// Purpose: shared constants and types of the interrupt entry/exit sequencer
// Assumes: 8-bit register port, 16-bit program and stack addresses
// Notes: stack pointer offsets are local choices
package ies_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] ADR_FLAGS = 8'hD5;
	localparam logic [7:0] ADR_SPH   = 8'hD8;
	localparam logic [7:0] ADR_SPL   = 8'hD9;
	localparam logic [7:0] ADR_FVPH  = 8'hDA;
	localparam logic [7:0] ADR_FVPL  = 8'hDB;
	localparam logic [7:0] ADR_IMR   = 8'hDD;
	localparam logic [7:0] ADR_SYM   = 8'hDE;
	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int SYM_GIE  = 0;
	localparam int SYM_FEN  = 1;
	localparam int SYM_FSEL = 2;
	localparam int FLG_BANK = 0;
	localparam int FLG_FIS  = 1;
	localparam int FLG_DEC  = 2;
	localparam logic [7:0]  FLAGS_RST = 8'h00;
	localparam logic [7:0]  IMR_RST   = 8'h00;
	localparam logic [15:0] SP_RST    = 16'h0000;
	localparam logic [15:0] FVP_RST   = 16'h0000;
	// ****************************************
	// timing counts in clock cycles
	// ****************************************
	localparam logic [4:0] FAST_CYCLES = 5'h06;
	localparam logic [4:0] NORM_CYCLES = 5'h10;
	typedef enum logic [3:0] {
		ST_IDLE, ST_PSH_L, ST_PSH_H, ST_PSH_F, ST_VEC_H, ST_VEC_L, ST_VEC_J,
		ST_WAIT, ST_RET_F, ST_RET_H, ST_RET_L, ST_RET_J
	} ies_state_t;
endpackage

// >>> core/ies_flags_if.sv
// Purpose: carries flag commands between sequencer and flag store
// Assumes: one clock domain
// Notes: none
`timescale 1ns/1ps
interface ies_flags_if;
	logic       alu_we;
	logic [7:0] alu_val;
	logic       reg_we;
	logic [7:0] reg_val;
	logic       pop_we;
	logic [7:0] pop_val;
	logic       sb0;
	logic       sb1;
	logic       fast_enter;
	logic       fast_leave;
	logic [7:0] flags;
	logic [7:0] shadow;
	modport ctl (output alu_we, alu_val, reg_we, reg_val, pop_we, pop_val,
		sb0, sb1, fast_enter, fast_leave, input flags, shadow);
	modport store (input alu_we, alu_val, reg_we, reg_val, pop_we, pop_val,
		sb0, sb1, fast_enter, fast_leave, output flags, shadow);
endinterface

// >>> core/ies_pick.sv
// Purpose: picks the winning level among qualified requests
// Assumes: level 0 has the highest priority
// Notes: combinational
`timescale 1ns/1ps
module ies_pick
(
	// requests
	input  wire logic [7:0] req,
	// result
	output logic            any,
	output logic [2:0]      level
);
	function automatic logic [2:0] first_set(input logic [7:0] v);
		first_set = 3'h0;
		for (int i = 7; i >= 0; i--)
		begin
			if (v[i])
				first_set = 3'(i);
		end
	endfunction

	assign any   = |req;
	assign level = first_set(req);

	a_pick_lowest: assert property (@(req) any |-> req[level] && ((req & ((8'h01 << level) - 8'h01)) == 8'h00))
		else $error("picked level is not the winning one");
endmodule

// >>> core/ies_flags.sv
// Purpose: condition flag register with fast shadow copy
// Assumes: commands arrive as one-cycle pulses
// Notes: shadow copy has no register address
`timescale 1ns/1ps
module ies_flags
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// commands and state
	ies_flags_if.store fi
);
	// ****************************************
	// flags
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			fi.flags <= ies_pkg::FLAGS_RST;
		else if (fi.fast_enter)
			fi.flags[ies_pkg::FLG_FIS] <= 1'b1;
		else if (fi.fast_leave)
		begin
			fi.flags <= fi.shadow;
			fi.flags[ies_pkg::FLG_FIS] <= 1'b0;
		end
		else if (fi.pop_we)
			fi.flags <= fi.pop_val;
		else
		begin
			// alu wins a collision with a direct write; result is not defined anyway
			if (fi.alu_we)
				fi.flags[7:ies_pkg::FLG_DEC] <= fi.alu_val[7:ies_pkg::FLG_DEC];
			else if (fi.reg_we)
				fi.flags <= fi.reg_val;
			if (fi.sb0)
				fi.flags[ies_pkg::FLG_BANK] <= 1'b0;
			else if (fi.sb1)
				fi.flags[ies_pkg::FLG_BANK] <= 1'b1;
		end
	end

	// ****************************************
	// shadow copy
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			fi.shadow <= ies_pkg::FLAGS_RST;
		else if (fi.fast_enter)
			fi.shadow <= fi.flags;
	end

	a_fast_shadow: assert property (@(posedge clk) disable iff (!rst_n) fi.fast_enter |=> fi.shadow == $past(fi.flags) && fi.flags[1])
		else $error("fast entry did not shadow flags");
	a_bank_select: assert property (@(posedge clk) disable iff (!rst_n) fi.sb1 && !fi.fast_enter && !fi.fast_leave && !fi.pop_we |=> fi.flags[0])
		else $error("bank one select not applied");
endmodule

// >>> core/ies_seq.sv
// Purpose: interrupt entry and return sequencer of the cpu core
// Assumes: memories answer a read one cycle after the strobe
// Notes: pc_in is the address of the next instruction at boundaries
//
// Summary of operation
// - serve only enabled, unmasked, winning, source-enabled requests
// - accept at instruction end, then interrupt cycle
// - entry clears global enable, saves, vectors
// - return restores pc, flags, sets global enable
// - vector table sits in 00H to FFH
// - push pc low, pc high, then flags
// - read vector high then low, jump
// - vector entries start at even addresses
// - nested entry allowed once handler re-enables
// - fast pointer is high byte, low byte pair
// - fast overhead 6 cycles, normal 16
// - three-bit field picks fast level, enable gates
// - fast entry copies flags into unmapped shadow
// - any level zero to seven may be fast
// - fast entry swaps pc, shadows, sets fast flag
// - fast return swaps back, restores, clears flag
// - fast works with either pending clear style
// - only fast enable switches fast; global gates all
// - flag bits: cond, decimal, fast, bank
// - alu and direct flag write collide: undefined
// - reset clears fast and global enable
// - fast flag blocks interrupts, forces fast return
// - bank ops clear or set bank bit
`timescale 1ns/1ps
module ies_seq
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// instruction stream
	input  wire logic        instr_end,
	input  wire logic        op_ei,
	input  wire logic        op_di,
	input  wire logic        op_interrupt_return_op,
	input  wire logic        op_sb0,
	input  wire logic        op_sb1,
	input  wire logic        alu_flag_we,
	input  wire logic [7:0]  alu_flags,
	// program counter
	input  wire logic [15:0] pc_in,
	output logic             busy,
	output logic             pc_load_r,
	output logic [15:0]      pc_new_r,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_we,
	input  wire logic [7:0]  reg_wdata,
	output logic [7:0]       reg_rdata_r,
	// interrupt sources
	input  wire logic [7:0]  src_pend,
	input  wire logic [7:0]  src_en,
	input  wire logic [7:0]  vec_addr,
	output logic             irq_ack_r,
	output logic [2:0]       ack_level_r,
	// stack memory
	output logic             mem_we_r,
	output logic             mem_re_r,
	output logic [15:0]      mem_addr_r,
	output logic [7:0]       mem_wdata_r,
	input  wire logic [7:0]  mem_rdata,
	// program memory
	output logic             prog_re_r,
	output logic [15:0]      prog_addr_r,
	input  wire logic [7:0]  prog_rdata,
	// status
	output logic [7:0]       flags_out,
	output logic             gie
);
	ies_pkg::ies_state_t st_r;
	ies_flags_if         fi ();
	logic                gie_r;
	logic                fen_r;
	logic [2:0]          fsel_r;
	logic [7:0]          imr_r;
	logic [15:0]         sp_r;
	logic [15:0]         fvp_r;
	logic [15:0]         ret_pc_r;
	logic [15:0]         tgt_r;
	logic [7:0]          vec_r;
	logic [4:0]          cnt_r;
	logic                pick_any;
	logic [2:0]          pick_lvl;
	logic                fast_service_flag;
	logic                accept;
	logic                accept_fast;
	logic                accept_norm;
	logic                interrupt_return_op_fast;
	logic                interrupt_return_op_norm;
	logic                sp_dec;
	logic                sp_inc;

	// ****************************************
	// qualification and acceptance
	// ****************************************
	ies_pick u_pick
	(
		.req   (src_pend & src_en & imr_r),
		.any   (pick_any),
		.level (pick_lvl)
	);

	assign fast_service_flag         = fi.flags[ies_pkg::FLG_FIS];
	// global enable and fast flag gate every level, fast ones too
	assign accept      = (st_r == ies_pkg::ST_IDLE) && instr_end && !op_interrupt_return_op
		&& gie_r && !fast_service_flag && pick_any;
	assign accept_fast = accept && fen_r && (pick_lvl == fsel_r);
	assign accept_norm = accept && !accept_fast;
	assign interrupt_return_op_fast   = (st_r == ies_pkg::ST_IDLE) && op_interrupt_return_op && fast_service_flag;
	assign interrupt_return_op_norm   = (st_r == ies_pkg::ST_IDLE) && op_interrupt_return_op && !fast_service_flag;
	assign sp_dec      = accept_norm || (st_r == ies_pkg::ST_PSH_L)
		|| (st_r == ies_pkg::ST_PSH_H);
	assign sp_inc      = interrupt_return_op_norm || (st_r == ies_pkg::ST_RET_F)
		|| (st_r == ies_pkg::ST_RET_H);
	assign busy        = (st_r != ies_pkg::ST_IDLE);
	assign flags_out   = fi.flags;
	assign gie         = gie_r;

	// ****************************************
	// flag store commands
	// ****************************************
	assign fi.alu_we     = alu_flag_we;
	assign fi.alu_val    = alu_flags;
	assign fi.reg_we     = reg_we && (reg_addr == ies_pkg::ADR_FLAGS);
	assign fi.reg_val    = reg_wdata;
	assign fi.pop_we     = (st_r == ies_pkg::ST_RET_H);
	assign fi.pop_val    = mem_rdata;
	assign fi.sb0        = op_sb0;
	assign fi.sb1        = op_sb1;
	assign fi.fast_enter = accept_fast;
	assign fi.fast_leave = interrupt_return_op_fast;

	ies_flags u_flags
	(
		.clk   (clk),
		.rst_n (rst_n),
		.fi    (fi.store)
	);

	// ****************************************
	// system mode and mask registers
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			gie_r <= 1'b0;
			fen_r <= 1'b0;
		end
		else
		begin
			if (reg_we && (reg_addr == ies_pkg::ADR_SYM))
			begin
				gie_r <= reg_wdata[ies_pkg::SYM_GIE];
				fen_r <= reg_wdata[ies_pkg::SYM_FEN];
			end
			if (op_ei)
				gie_r <= 1'b1;
			else if (op_di)
				gie_r <= 1'b0;
			if (interrupt_return_op_fast || interrupt_return_op_norm)
				gie_r <= 1'b1;
			if (accept)
				gie_r <= 1'b0;
		end
	end

	// fast level select is left as is by reset
	always_ff @(posedge clk)
	begin
		if (reg_we && (reg_addr == ies_pkg::ADR_SYM))
			fsel_r <= reg_wdata[ies_pkg::SYM_FSEL +: 3];
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			imr_r <= ies_pkg::IMR_RST;
		else if (reg_we && (reg_addr == ies_pkg::ADR_IMR))
			imr_r <= reg_wdata;
	end

	// ****************************************
	// fast vector pointer
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			fvp_r <= ies_pkg::FVP_RST;
		else if (accept_fast || interrupt_return_op_fast)
			fvp_r <= pc_in;
		else if (reg_we && (reg_addr == ies_pkg::ADR_FVPH))
			fvp_r[15:8] <= reg_wdata;
		else if (reg_we && (reg_addr == ies_pkg::ADR_FVPL))
			fvp_r[7:0] <= reg_wdata;
	end

	// ****************************************
	// stack pointer
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sp_r <= ies_pkg::SP_RST;
		else if (sp_dec)
			sp_r <= sp_r - 16'h0001;
		else if (sp_inc)
			sp_r <= sp_r + 16'h0001;
		else if (reg_we && (reg_addr == ies_pkg::ADR_SPH))
			sp_r[15:8] <= reg_wdata;
		else if (reg_we && (reg_addr == ies_pkg::ADR_SPL))
			sp_r[7:0] <= reg_wdata;
	end

	// ****************************************
	// stack bus
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			mem_we_r    <= 1'b0;
			mem_re_r    <= 1'b0;
			mem_addr_r  <= 16'h0000;
			mem_wdata_r <= 8'h00;
		end
		else
		begin
			mem_we_r   <= sp_dec;
			mem_re_r   <= sp_inc;
			mem_addr_r <= sp_dec ? (sp_r - 16'h0001) : sp_r;
			if (accept_norm)
				mem_wdata_r <= pc_in[7:0];
			else if (st_r == ies_pkg::ST_PSH_L)
				mem_wdata_r <= ret_pc_r[15:8];
			else if (st_r == ies_pkg::ST_PSH_H)
				mem_wdata_r <= fi.flags;
		end
	end

	// ****************************************
	// vector fetch bus
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			prog_re_r   <= 1'b0;
			prog_addr_r <= 16'h0000;
		end
		else
		begin
			prog_re_r   <= (st_r == ies_pkg::ST_PSH_F) || (st_r == ies_pkg::ST_VEC_H);
			// table lives in the first page; low bit picks the second byte
			prog_addr_r <= {8'h00, vec_r[7:1], st_r == ies_pkg::ST_VEC_H};
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_r        <= ies_pkg::ST_IDLE;
			cnt_r       <= 5'h00;
			ret_pc_r    <= 16'h0000;
			tgt_r       <= 16'h0000;
			vec_r       <= 8'h00;
			irq_ack_r   <= 1'b0;
			ack_level_r <= 3'h0;
			pc_load_r   <= 1'b0;
			pc_new_r    <= 16'h0000;
		end
		else
		begin
			irq_ack_r <= accept;
			pc_load_r <= 1'b0;
			if (st_r != ies_pkg::ST_IDLE)
				cnt_r <= cnt_r - 5'h01;
			unique case (st_r)
				ies_pkg::ST_IDLE:
				begin
					if (accept)
					begin
						ack_level_r <= pick_lvl;
						ret_pc_r    <= pc_in;
						vec_r       <= {vec_addr[7:1], 1'b0};
						tgt_r       <= fvp_r;
						cnt_r       <= accept_fast ? (ies_pkg::FAST_CYCLES - 5'h01)
							: (ies_pkg::NORM_CYCLES - 5'h01);
						st_r        <= accept_fast ? ies_pkg::ST_WAIT : ies_pkg::ST_PSH_L;
					end
					else if (interrupt_return_op_fast)
					begin
						pc_load_r <= 1'b1;
						pc_new_r  <= fvp_r;
					end
					else if (interrupt_return_op_norm)
						st_r <= ies_pkg::ST_RET_F;
				end
				ies_pkg::ST_PSH_L: st_r <= ies_pkg::ST_PSH_H;
				ies_pkg::ST_PSH_H: st_r <= ies_pkg::ST_PSH_F;
				ies_pkg::ST_PSH_F: st_r <= ies_pkg::ST_VEC_H;
				ies_pkg::ST_VEC_H: st_r <= ies_pkg::ST_VEC_L;
				ies_pkg::ST_VEC_L:
				begin
					tgt_r[15:8] <= prog_rdata;
					st_r        <= ies_pkg::ST_VEC_J;
				end
				ies_pkg::ST_VEC_J:
				begin
					tgt_r[7:0] <= prog_rdata;
					st_r       <= ies_pkg::ST_WAIT;
				end
				ies_pkg::ST_WAIT:
				begin
					// stall pads entry to its fixed overhead
					if (cnt_r == 5'h00)
					begin
						pc_load_r <= 1'b1;
						pc_new_r  <= tgt_r;
						st_r      <= ies_pkg::ST_IDLE;
					end
				end
				ies_pkg::ST_RET_F: st_r <= ies_pkg::ST_RET_H;
				ies_pkg::ST_RET_H: st_r <= ies_pkg::ST_RET_L;
				ies_pkg::ST_RET_L:
				begin
					tgt_r[15:8] <= mem_rdata;
					st_r        <= ies_pkg::ST_RET_J;
				end
				ies_pkg::ST_RET_J:
				begin
					pc_load_r <= 1'b1;
					pc_new_r  <= {tgt_r[15:8], mem_rdata};
					st_r      <= ies_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// register read-back
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			reg_rdata_r <= 8'h00;
		else
		begin
			unique case (reg_addr)
				ies_pkg::ADR_FLAGS: reg_rdata_r <= fi.flags;
				ies_pkg::ADR_SPH:   reg_rdata_r <= sp_r[15:8];
				ies_pkg::ADR_SPL:   reg_rdata_r <= sp_r[7:0];
				ies_pkg::ADR_FVPH:  reg_rdata_r <= fvp_r[15:8];
				ies_pkg::ADR_FVPL:  reg_rdata_r <= fvp_r[7:0];
				ies_pkg::ADR_IMR:   reg_rdata_r <= imr_r;
				ies_pkg::ADR_SYM:   reg_rdata_r <= {3'h0, fsel_r, fen_r, gie_r};
				default:            reg_rdata_r <= 8'h00;
			endcase
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_push3;
		mem_we_r ##1 mem_we_r && mem_addr_r == $past(mem_addr_r) - 16'h0001
		##1 mem_we_r && mem_wdata_r == $past(fi.flags, 3);
	endsequence
	sequence s_pop3;
		mem_re_r ##1 mem_re_r && mem_addr_r == $past(mem_addr_r) + 16'h0001
		##1 mem_re_r;
	endsequence

	a_gie_cleared: assert property (accept |=> !gie_r)
		else $error("entry left global enable set");
	a_interrupt_return_op_gie: assert property ((interrupt_return_op_fast || interrupt_return_op_norm) |=> gie_r)
		else $error("return did not set global enable");
	a_push_seq: assert property (accept_norm |=> mem_wdata_r == $past(pc_in[7:0]) and s_push3)
		else $error("vectored entry push order wrong");
	a_pop_seq: assert property (interrupt_return_op_norm |=> s_pop3 ##2 pc_load_r)
		else $error("return pop sequence wrong");
	a_norm_len: assert property (accept_norm |-> ##17 pc_load_r)
		else $error("normal entry overhead wrong");
	a_fast_len: assert property (accept_fast |-> ##7 pc_load_r && pc_new_r == $past(fvp_r, 7))
		else $error("fast entry overhead wrong");
	a_vec_even: assert property (st_r == ies_pkg::ST_VEC_H |-> !prog_addr_r[0] && prog_addr_r[15:8] == 8'h00)
		else $error("vector address not even in table");
	a_ack_boundary: assert property (irq_ack_r |-> $past(instr_end) && !gie_r)
		else $error("acknowledge off instruction boundary");
	a_fast_swap: assert property (accept_fast |=> fvp_r == $past(pc_in) && fast_service_flag)
		else $error("fast entry swap missing");
	a_fast_ret: assert property (interrupt_return_op_fast |=> pc_load_r && pc_new_r == $past(fvp_r) && !fast_service_flag)
		else $error("fast return swap missing");
	// the fast entry's own acknowledge overlaps the first cycle of the flag
	a_fis_blocks: assert property (fast_service_flag |=> !irq_ack_r)
		else $error("interrupt taken while fast flag set");
endmodule

// >>> verification/ies_src_model.sv
// Purpose: peripheral sources and level logic beside the sequencer
// Assumes: levels in HW_CLR clear on acknowledge, others by the handler
// Notes: vector byte follows the lowest enabled pending level
`timescale 1ns/1ps
module ies_src_model
#(
	parameter logic [7:0] HW_CLR   = 8'h0F,
	parameter logic [7:0] VEC_BASE = 8'h40
)
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// bench control
	input  wire logic [7:0] raise,
	input  wire logic [7:0] soft_clr,
	input  wire logic [7:0] en_in,
	// acknowledge
	input  wire logic       irq_ack_r,
	input  wire logic [2:0] ack_level_r,
	// requests
	output logic [7:0]      src_pend,
	output logic [7:0]      src_en,
	output logic [7:0]      vec_addr
);
	logic [7:0] hw_hit;
	assign src_en = en_in;
	// both clear styles must coexist
	assign hw_hit = irq_ack_r ? (HW_CLR & (8'h01 << ack_level_r)) : 8'h00;
	always_ff @(posedge clk)
		if (!rst_n)
			src_pend <= 8'h00;
		else
			src_pend <= (src_pend | raise) & ~hw_hit & ~soft_clr;
	always_comb
	begin
		vec_addr = VEC_BASE;
		for (int i = 7; i >= 0; i--)
			if (src_pend[i] & src_en[i])
				vec_addr = VEC_BASE + 8'(2 * i);
	end
endmodule

// >>> verification/tb_cpu_interrupt_entry_exit_sequencer.sv
// Purpose: self-checking bench of the interrupt sequencer
// Assumes: inputs change at the falling edge
// Notes: stack and program memory answer one cycle after the strobe
`timescale 1ns/1ps
module tb_cpu_interrupt_entry_exit_sequencer;
	localparam logic [7:0] VB = 8'h40;
	logic clk = 1'b0, rst_n = 1'b0, instr_end = 1'b0, op_ei = 1'b0, op_di = 1'b0;
	logic op_interrupt_return_op = 1'b0, op_sb0 = 1'b0, op_sb1 = 1'b0, alu_flag_we = 1'b0, reg_we = 1'b0;
	logic [7:0] alu_flags = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_r;
	logic [7:0] raise = 8'h00, soft_clr = 8'h00, en_in = 8'hFF, src_pend, src_en;
	logic [7:0] vec_addr, mem_wdata_r, flags_out, mem_rdata = 8'h00, prog_rdata = 8'h00;
	logic [15:0] pc_in = 16'h0000, pc_new_r, mem_addr_r, prog_addr_r, last_pa;
	logic busy, pc_load_r, irq_ack_r, mem_we_r, mem_re_r, prog_re_r, gie;
	logic [2:0] ack_level_r;
	logic [7:0] stk [0:255];
	logic [7:0] rom [0:255];
	int n_errors = 0, n_compared = 0, n_push = 0, n_busy = 0, n_ack = 0;
	ies_seq u_dut (.*);
	ies_src_model #(.VEC_BASE(VB)) u_src (.*);
	always #25 clk = ~clk;
	// ****
	// memories: idle read lines toggle so stale data never passes
	// ****
	always @(posedge clk)
	begin
		if (mem_we_r)
		begin
			stk[mem_addr_r[7:0]] <= mem_wdata_r;
			n_push <= n_push + 1;
		end
		if (busy)
			n_busy <= n_busy + 1;
		if (irq_ack_r)
			n_ack <= n_ack + 1;
		mem_rdata <= mem_re_r ? stk[mem_addr_r[7:0]] : ~mem_rdata;
		prog_rdata <= prog_re_r ? rom[prog_addr_r[7:0]] : ~prog_rdata;
		if (prog_re_r)
			last_pa <= prog_addr_r;
	end
	// ****
	// helpers
	// ****
	task automatic check(input string what, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask
	task automatic ctl(ref logic [7:0] v, input logic [7:0] x);
		@(negedge clk);
		v = x;
		@(negedge clk);
		v = 8'h00;
	endtask
	task automatic reg_wr(input logic [7:0] a, d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_we = 1'b1;
		@(negedge clk);
		reg_we = 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		d = reg_rdata_r;
	endtask
	// k: cycles from the boundary to the pc load, 40 if none came
	task automatic strike(input logic e, r, input logic [15:0] pc, output int k);
		@(negedge clk);
		instr_end = e;
		op_interrupt_return_op = r;
		pc_in = pc;
		k = 0;
		do
		begin
			@(negedge clk);
			instr_end = 1'b0;
			op_interrupt_return_op = 1'b0;
			k++;
		end
		while (pc_load_r !== 1'b1 && k < 40);
	endtask
	function automatic logic [15:0] vec(int l);
		return {rom[8'(VB + 2 * l)], rom[8'(VB + 2 * l + 1)]};
	endfunction
	// ****
	// scenarios
	// ****
	task automatic t_reset();
		logic [7:0] a [7] = '{8'hD5, 8'hDD, 8'hDA, 8'hDB, 8'hD8, 8'hD9, 8'h10};
		logic [7:0] d;
		foreach (a[i])
		begin
			reg_rd(a[i], d);
			check("reset reg", d, 8'h00);
		end
		reg_rd(ies_pkg::ADR_SYM, d);
		check("mode", d[1:0], 2'b00);
		check("gie", gie, 1'b0);
	endtask
	task automatic t_gate();
		logic [7:0] imr_v [3] = '{8'h04, 8'h00, 8'h04};
		logic [7:0] en_v [3] = '{8'hFF, 8'hFF, 8'hFB};
		int k;
		for (int c = 0; c < 3; c++)
		begin
			reg_wr(ies_pkg::ADR_IMR, imr_v[c]);
			en_in = en_v[c];
			if (c == 1)
				pulse(op_ei);
			ctl(raise, 8'h04);
			strike(1'b1, 1'b0, 16'h0100, k);
			check("refused", 16'(k), 16'd40);
		end
		check("ei", gie, 1'b1);
		ctl(soft_clr, 8'h04);
		en_in = 8'hFF;
		pulse(op_di);
	endtask
	task automatic t_normal();
		logic [7:0] d;
		int k, p0, b0, a0;
		reg_wr(ies_pkg::ADR_SPH, 8'h01);
		reg_wr(ies_pkg::ADR_SPL, 8'h00);
		reg_wr(ies_pkg::ADR_FLAGS, 8'hC8);
		reg_wr(ies_pkg::ADR_IMR, 8'h2A);
		reg_wr(ies_pkg::ADR_SYM, 8'h0D);
		ctl(raise, 8'h28);
		p0 = n_push;
		b0 = n_busy;
		a0 = n_ack;
		strike(1'b1, 1'b0, 16'h1234, k);
		check("entry", 16'(k), 16'd17);
		check("target", pc_new_r, vec(3));
		check("level", ack_level_r, 3'd3);
		check("vec read", last_pa, 16'h0047);
		check("pcl", stk[8'hFF], 8'h34);
		check("pch", stk[8'hFE], 8'h12);
		check("flags", stk[8'hFD], 8'hC8);
		check("pushes", 16'(n_push - p0), 16'd3);
		check("busy", 16'(n_busy - b0), 16'h0010);
		check("ack", 16'(n_ack - a0), 16'h0001);
		check("gie", gie, 1'b0);
		reg_rd(ies_pkg::ADR_SPL, d);
		check("sp", d, 8'hFD);
		reg_wr(ies_pkg::ADR_IMR, 8'h02);
		pulse(op_ei);
		ctl(raise, 8'h02);
		strike(1'b1, 1'b0, 16'h4444, k);
		check("nest", 16'(k), 16'd17);
		check("nest target", pc_new_r, vec(1));
		check("nest pcl", stk[8'hFC], 8'h44);
		alu_flags = 8'h54;
		pulse(alu_flag_we);
		strike(1'b0, 1'b1, 16'h0000, k);
		check("return", 16'(k), 16'd5);
		check("ret pc", pc_new_r, 16'h4444);
		strike(1'b0, 1'b1, 16'h0000, k);
		check("ret pc2", pc_new_r, 16'h1234);
		check("ret flags", flags_out, 8'hC8);
		check("ret gie", gie, 1'b1);
		reg_rd(ies_pkg::ADR_SPL, d);
		check("sp back", d, 8'h00);
		ctl(soft_clr, 8'h20);
		pulse(op_di);
	endtask
	task automatic t_fast();
		logic [7:0] d;
		int k, p0, b0, a0;
		for (int l = 0; l < 8; l++)
		begin
			reg_wr(ies_pkg::ADR_FVPH, 8'h20);
			reg_wr(ies_pkg::ADR_FVPL, 8'(l));
			reg_wr(ies_pkg::ADR_IMR, 8'hFF);
			reg_wr(ies_pkg::ADR_FLAGS, 8'hA4);
			reg_wr(ies_pkg::ADR_SYM, {3'b000, 3'(l), 2'b11});
			p0 = n_push;
			b0 = n_busy;
			a0 = n_ack;
			ctl(raise, 8'h01 << l);
			strike(1'b1, 1'b0, 16'h3000, k);
			check("fast", 16'(k), 16'd7);
			check("fast pc", pc_new_r, {8'h20, 8'(l)});
			check("fast flags", flags_out, 8'hA6);
			check("no push", 16'(n_push - p0), 16'd0);
			check("fast busy", 16'(n_busy - b0), 16'h0006);
			check("fast ack", 16'(n_ack - a0), 16'h0001);
			if (l >= 4)
				ctl(soft_clr, 8'h01 << l);
			reg_rd(ies_pkg::ADR_FVPH, d);
			check("ptr high", d, 8'h30);
			pulse(op_ei);
			ctl(raise, 8'h01 << (7 - l));
			a0 = n_ack;
			strike(1'b1, 1'b0, 16'h3010, k);
			check("blocked", 16'(k), 16'd40);
			check("blocked ack", 16'(n_ack - a0), 16'h0000);
			alu_flags = 8'h18;
			pulse(alu_flag_we);
			strike(1'b0, 1'b1, 16'h3050, k);
			check("fast ret", 16'(k), 16'd1);
			check("fret pc", pc_new_r, 16'h3000);
			check("fret flags", flags_out, 8'hA4);
			reg_rd(ies_pkg::ADR_FVPL, d);
			check("ptr low", d, 8'h50);
			ctl(soft_clr, 8'hFF);
			pulse(op_di);
		end
	endtask
	task automatic t_bank();
		pulse(op_sb1);
		check("bank1", flags_out[0], 1'b1);
		alu_flags = 8'hFF;
		pulse(alu_flag_we);
		check("alu", flags_out, 8'hFD);
		pulse(op_sb0);
		check("bank0", flags_out, 8'hFC);
	endtask
	task automatic complete_run();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		for (int i = 0; i < 256; i++)
			rom[i] = 8'(i * 7 + 3);
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_gate();
		t_normal();
		t_fast();
		t_bank();
		complete_run();
	end
	initial
	begin
		#(50 * 20000);
		n_errors++;
		complete_run();
	end
endmodule
